// file: inc/tsom_defines.vh
// tsom_defines.vh: offsets, field positions, reset values and codes of the
// test signal observation mux; included by the observation mux design only, no logic here
`ifndef TSOM_DEFINES_VH
`define TSOM_DEFINES_VH

// register byte offsets on the ahb-lite bus
`define TSOM_OFS_OBSERVE      8'h00
`define TSOM_OFS_ANALOG       8'h04
`define TSOM_OFS_DIGITAL      8'h08
`define TSOM_OFS_STATUS       8'h0C

// observe control register fields
`define TSOM_OBS_SEL_LSB      0
`define TSOM_OBS_SEL_MSB      2
`define TSOM_OBS_ROUTE_BIT    3
`define TSOM_OBS_RST          4'h0

// analog probe register fields
`define TSOM_ANA_MSB          4
`define TSOM_ANA_RST          5'h00
`define TSOM_ANA_LAST         5'h0C

// digital probe register fields
`define TSOM_DIG_MSB          7
`define TSOM_DIG_RST          8'h00

// observe select codes
`define TSOM_SEL_LOW          3'h0
`define TSOM_SEL_HIGH         3'h1
`define TSOM_SEL_ENVELOPE     3'h2
`define TSOM_SEL_NRZ          3'h3
`define TSOM_SEL_MANCH_SUB    3'h4
`define TSOM_SEL_MANCH        3'h5

// digital probe codes
`define TSOM_DIG_NONE         8'h00
`define TSOM_DIG_RX_DATA      8'hF4
`define TSOM_DIG_RX_VALID     8'hE4
`define TSOM_DIG_RX_COLL      8'hD4
`define TSOM_DIG_BIT_CLK      8'hC4
`define TSOM_DIG_RD_SYNC      8'hB5
`define TSOM_DIG_WR_SYNC      8'hA5
`define TSOM_DIG_CORE_CLK     8'h96

// ahb-lite encodings
`define TSOM_HTRANS_NONSEQ    2'h2
`define TSOM_HTRANS_SEQ       2'h3
`define TSOM_HSIZE_WORD       3'h2

`endif

// file: design/tsom_cfg_reg.v
// tsom_cfg_reg.v: one software-writable configuration field with reset value
// assumes a single write strobe that is valid for one hclk cycle
`timescale 1ns/100ps

module tsom_cfg_reg #(
    parameter WIDTH     = 8,
    parameter RST_VALUE = 8'h00
) (
    input  wire             hclk,
    input  wire             hresetn,
    input  wire             wr_en,
    input  wire [WIDTH-1:0] wr_data,
    output wire [WIDTH-1:0] value
);

    reg [WIDTH-1:0] value_q;
    reg [WIDTH-1:0] value_d;

    // hold unless written
    always @* begin
        value_d = value_q;
        if (wr_en) begin
            value_d = wr_data;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            value_q <= RST_VALUE[WIDTH-1:0];
        end else begin
            value_q <= value_d;
        end
    end

    assign value = value_q;

endmodule // tsom_cfg_reg

// file: design/tsom_observe_mux.v
// tsom_observe_mux.v: test signal observation mux with ahb-lite registers
// assumes all probe inputs are synchronous to hclk, single ahb master
//
// Implementation choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/100ps
`include "tsom_defines.vh"

module tsom_observe_mux (
    input  wire        hclk,
    input  wire        hresetn,
    // ahb-lite slave
    input  wire        hsel,
    input  wire [7:0]  haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    // transmit path
    input  wire        tx_active,
    input  wire        tx_nrz,
    input  wire        tx_envelope,
    input  wire        tx_enc_clk,
    // receive path
    input  wire        rx_manch_sub,
    input  wire        rx_manch,
    input  wire        rx_clk,
    input  wire        rx_bit_start,
    input  wire        rx_bit_done,
    input  wire        rx_bit_data,
    input  wire        rx_coll_det,
    input  wire        rx_frame_end,
    // host strobes and core clock copy
    input  wire        host_rd_sync,
    input  wire        host_wr_sync,
    input  wire        core_clk_level,
    // pins and analog mux control
    output reg         observe_pin,
    output reg  [4:0]  analog_probe_choice,
    output reg  [12:0] analog_node_en
);

    // ------------------------------------------------------------------
    // ahb-lite address phase capture
    // ------------------------------------------------------------------
    reg        wr_pend_q;
    reg        wr_pend_d;
    reg [7:0]  wr_addr_q;
    reg [7:0]  wr_addr_d;
    wire       addr_ok;
    wire       take;

    assign addr_ok = (hsize == `TSOM_HSIZE_WORD) && (haddr[1:0] == 2'h0);
    assign take    = hsel && hready && addr_ok
                     && ((htrans == `TSOM_HTRANS_NONSEQ) || (htrans == `TSOM_HTRANS_SEQ));

    always @* begin
        wr_pend_d = 1'b0;
        wr_addr_d = wr_addr_q;
        if (take && hwrite) begin
            wr_pend_d = 1'b1;
            wr_addr_d = haddr;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
        end
    end

    // write strobes in the data phase
    reg wr_obs;
    reg wr_ana;
    reg wr_dig;

    always @* begin
        wr_obs = 1'b0;
        wr_ana = 1'b0;
        wr_dig = 1'b0;
        if (wr_pend_q) begin
            if (wr_addr_q == `TSOM_OFS_OBSERVE) begin
                wr_obs = 1'b1;
            end else if (wr_addr_q == `TSOM_OFS_ANALOG) begin
                wr_ana = 1'b1;
            end else if (wr_addr_q == `TSOM_OFS_DIGITAL) begin
                wr_dig = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    wire [3:0] obs_cfg;
    wire [4:0] ana_cfg;
    wire [7:0] dig_cfg;

    tsom_cfg_reg #(
        .WIDTH     (4),
        .RST_VALUE (`TSOM_OBS_RST)
    ) u_obs_reg (
        .hclk    (hclk),
        .hresetn (hresetn),
        .wr_en   (wr_obs),
        .wr_data (hwdata[3:0]),
        .value   (obs_cfg)
    );

    tsom_cfg_reg #(
        .WIDTH     (5),
        .RST_VALUE (`TSOM_ANA_RST)
    ) u_ana_reg (
        .hclk    (hclk),
        .hresetn (hresetn),
        .wr_en   (wr_ana),
        .wr_data (hwdata[`TSOM_ANA_MSB:0]),
        .value   (ana_cfg)
    );

    tsom_cfg_reg #(
        .WIDTH     (8),
        .RST_VALUE (`TSOM_DIG_RST)
    ) u_dig_reg (
        .hclk    (hclk),
        .hresetn (hresetn),
        .wr_en   (wr_dig),
        .wr_data (hwdata[`TSOM_DIG_MSB:0]),
        .value   (dig_cfg)
    );

    wire [2:0] observe_pin_select;
    wire       test_route_flag;

    assign observe_pin_select = obs_cfg[`TSOM_OBS_SEL_MSB:`TSOM_OBS_SEL_LSB];
    assign test_route_flag    = obs_cfg[`TSOM_OBS_ROUTE_BIT];

    // ------------------------------------------------------------------
    // received bit qualifiers
    // ------------------------------------------------------------------
    reg rx_data_q;
    reg rx_data_d;
    reg rx_valid_q;
    reg rx_valid_d;
    reg rx_coll_q;
    reg rx_coll_d;
    reg coll_cur_q;
    reg coll_cur_d;

    always @* begin
        rx_data_d  = rx_data_q;
        rx_valid_d = rx_valid_q;
        rx_coll_d  = rx_coll_q;
        coll_cur_d = coll_cur_q;
        // collision seen anywhere inside the bit being received
        if (rx_bit_start) begin
            coll_cur_d = rx_coll_det;
        end else if (rx_coll_det) begin
            coll_cur_d = 1'b1;
        end
        // data and collision become valid together at bit end
        if (rx_bit_done) begin
            rx_data_d  = rx_bit_data;
            rx_coll_d  = coll_cur_q | rx_coll_det;
            rx_valid_d = 1'b1;
        end else if (rx_bit_start || rx_frame_end) begin
            rx_valid_d = 1'b0;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_data_q  <= 1'b0;
            rx_valid_q <= 1'b0;
            rx_coll_q  <= 1'b0;
            coll_cur_q <= 1'b0;
        end else begin
            rx_data_q  <= rx_data_d;
            rx_valid_q <= rx_valid_d;
            rx_coll_q  <= rx_coll_d;
            coll_cur_q <= coll_cur_d;
        end
    end

    // ------------------------------------------------------------------
    // digital probe selection
    // ------------------------------------------------------------------
    reg digital_probe_choice;
    reg probe_listed;

    always @* begin
        digital_probe_choice = 1'b0;
        probe_listed         = 1'b1;
        if (dig_cfg == `TSOM_DIG_RX_DATA) begin
            digital_probe_choice = rx_data_q;
        end else if (dig_cfg == `TSOM_DIG_RX_VALID) begin
            digital_probe_choice = rx_valid_q;
        end else if (dig_cfg == `TSOM_DIG_RX_COLL) begin
            digital_probe_choice = rx_coll_q;
        end else if (dig_cfg == `TSOM_DIG_BIT_CLK) begin
            digital_probe_choice = tx_active ? tx_enc_clk : rx_clk;
        end else if (dig_cfg == `TSOM_DIG_RD_SYNC) begin
            digital_probe_choice = host_rd_sync;
        end else if (dig_cfg == `TSOM_DIG_WR_SYNC) begin
            digital_probe_choice = host_wr_sync;
        end else if (dig_cfg == `TSOM_DIG_CORE_CLK) begin
            digital_probe_choice = core_clk_level;
        end else if (dig_cfg != `TSOM_DIG_NONE) begin
            // production test codes are not served, pin held low when routed
            probe_listed = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // serial signal switch
    // ------------------------------------------------------------------
    reg switch_level;

    always @* begin
        case (observe_pin_select)
            `TSOM_SEL_LOW:       switch_level = 1'b0;
            `TSOM_SEL_HIGH:      switch_level = 1'b1;
            `TSOM_SEL_ENVELOPE:  switch_level = tx_envelope;
            `TSOM_SEL_NRZ:       switch_level = tx_nrz;
            `TSOM_SEL_MANCH_SUB: switch_level = rx_manch_sub;
            `TSOM_SEL_MANCH:     switch_level = rx_manch;
            default:             switch_level = 1'b0;
        endcase
    end

    reg observe_d;

    always @* begin
        if (test_route_flag && (dig_cfg != `TSOM_DIG_NONE)) begin
            observe_d = digital_probe_choice;
        end else begin
            observe_d = switch_level;
        end
    end

    // ------------------------------------------------------------------
    // analog probe selection
    // ------------------------------------------------------------------
    reg [12:0] node_en_d;
    reg        ana_listed;

    always @* begin
        node_en_d  = 13'h0000;
        ana_listed = (ana_cfg <= `TSOM_ANA_LAST);
        if (ana_listed) begin
            node_en_d[ana_cfg[3:0]] = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // pin and analog control outputs
    // ------------------------------------------------------------------
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            observe_pin         <= 1'b0;
            analog_probe_choice <= 5'h00;
            analog_node_en      <= 13'h0000;
        end else begin
            observe_pin         <= observe_d;
            analog_probe_choice <= ana_cfg;
            analog_node_en      <= node_en_d;
        end
    end

    // ------------------------------------------------------------------
    // read data and response
    // ------------------------------------------------------------------
    reg [31:0] rdata_d;
    wire [31:0] status_word;

    assign status_word = {20'h00000,
                          ana_listed,
                          probe_listed,
                          rx_coll_q,
                          rx_valid_q,
                          rx_data_q,
                          tx_active,
                          switch_level,
                          digital_probe_choice,
                          observe_pin,
                          test_route_flag && (dig_cfg != `TSOM_DIG_NONE),
                          observe_pin_select[1:0] == 2'h0 ? 1'b0 : 1'b1,
                          1'b0};

    always @* begin
        rdata_d = 32'h00000000;
        if (take && !hwrite) begin
            if (haddr == `TSOM_OFS_OBSERVE) begin
                rdata_d = {28'h0000000, obs_cfg};
            end else if (haddr == `TSOM_OFS_ANALOG) begin
                rdata_d = {27'h0, ana_cfg};
            end else if (haddr == `TSOM_OFS_DIGITAL) begin
                rdata_d = {24'h000000, dig_cfg};
            end else if (haddr == `TSOM_OFS_STATUS) begin
                rdata_d = status_word;
            end
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hrdata    <= rdata_d;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

endmodule // tsom_observe_mux

// file: bench/tsom_probe.sv
// tsom_probe.sv: lab probe on the analog monitor node enables
// assumes analog_node_en is registered on hclk
`timescale 1ns/100ps

module tsom_probe (
    input  wire        hclk,
    input  wire [12:0] analog_node_en,
    output reg  [4:0]  node_q
);
    integer i;

    // node index seen on the monitor pin, 1Fh when none or several
    always @(posedge hclk) begin
        node_q <= 5'h1F;
        for (i = 0; i < 13; i = i + 1) begin
            if (analog_node_en == (13'h1 << i)) node_q <= i[4:0];
        end
    end
endmodule // tsom_probe

// file: bench/tsom_observe_mux_checker.sv
// tsom_observe_mux_checker.sv: port assertions of the observation mux
// assumes hready is the slave's own hreadyout and a single bus master
`timescale 1ns/100ps

module tsom_observe_mux_checker (
    input wire        hclk,
    input wire        hresetn,
    input wire        hsel,
    input wire [7:0]  haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [2:0]  hsize,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire        tx_active,
    input wire        tx_nrz,
    input wire        tx_envelope,
    input wire        tx_enc_clk,
    input wire        rx_manch_sub,
    input wire        rx_manch,
    input wire        rx_clk,
    input wire        host_rd_sync,
    input wire        host_wr_sync,
    input wire        core_clk_level,
    input wire        observe_pin,
    input wire [4:0]  analog_probe_choice,
    input wire [12:0] analog_node_en
);
    reg        ap_q;
    reg [7:0]  aa_q;
    reg [3:0]  obs_q;
    reg [4:0]  ana_q;
    reg [7:0]  dig_q;
    wire [2:0] sel  = obs_q[2:0];
    wire       md   = !obs_q[3] || dig_q == 8'h00;
    wire       txs  = sel[0] ? tx_nrz : tx_envelope;
    wire       mnc  = sel[0] ? rx_manch : rx_manch_sub;
    wire       bclk = tx_active ? tx_enc_clk : rx_clk;
    wire       strb = dig_q[4] ? host_rd_sync : host_wr_sync;

    // shadow of the configuration written over the bus
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_q  <= 1'b0;
            aa_q  <= 8'h00;
            obs_q <= 4'h0;
            ana_q <= 5'h00;
            dig_q <= 8'h00;
        end else begin
            ap_q <= hsel && hready && htrans[1] && hwrite && hsize == 3'h2;
            aa_q <= haddr;
            if (ap_q && aa_q == 8'h00) obs_q <= hwdata[3:0];
            if (ap_q && aa_q == 8'h04) ana_q <= hwdata[4:0];
            if (ap_q && aa_q == 8'h08) dig_q <= hwdata[7:0];
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    AST_FIXED: assert property (md && sel < 3'h2 |=> observe_pin == $past(obs_q[0]))
        else $error("pin not at fixed level");
    AST_TX: assert property (md && sel[2:1] == 2'b01 |=> observe_pin == $past(txs))
        else $error("pin not following transmit source");
    AST_MANCH: assert property (md && sel[2:1] == 2'b10 |=> observe_pin == $past(mnc))
        else $error("pin not following receive source");
    AST_RSV: assert property (md && sel > 3'h5 |=> !observe_pin)
        else $error("pin not low for reserved select");
    AST_BCLK: assert property (!md && dig_q == 8'hC4 |=> observe_pin == $past(bclk))
        else $error("pin not following bit clock");
    AST_STRB: assert property (!md && (dig_q == 8'hB5 || dig_q == 8'hA5) |=>
        observe_pin == $past(strb)) else $error("pin not following host strobe");
    AST_CCLK: assert property (!md && dig_q == 8'h96 |=> observe_pin == $past(core_clk_level))
        else $error("pin not following core clock");
    AST_ANA: assert property (1'b1 |=> analog_probe_choice == $past(ana_q))
        else $error("analog choice not following field");
    AST_NODE: assert property (ana_q <= 5'h0C |=> analog_node_en == 13'h1 << $past(ana_q))
        else $error("wrong analog node enabled");
    AST_NODE_RSV: assert property (ana_q > 5'h0C |=> analog_node_en == 13'h0000)
        else $error("node enabled for reserved code");

    COV_ROUTE: cover property (!md && dig_q == 8'hC4 && !tx_active);
    COV_MANCH: cover property (md && sel == 3'h5);
    COV_LAST: cover property (ana_q == 5'h0C);
endmodule // tsom_observe_mux_checker

bind tsom_observe_mux tsom_observe_mux_checker u_chk (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .tx_active, .tx_nrz, .tx_envelope, .tx_enc_clk, .rx_manch_sub, .rx_manch, .rx_clk,
    .host_rd_sync, .host_wr_sync, .core_clk_level, .observe_pin, .analog_probe_choice,
    .analog_node_en
);

// file: bench/tb.sv
// tb.sv: self-checking bench of the observation mux over ahb-lite
// assumes zero wait states are possible but waits on hreadyout anyway
`timescale 1ns/100ps

module tb;
    logic        hclk, hresetn, hsel, hwrite, tx_active;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, rd_q;
    logic [8:0]  src;
    logic [4:0]  rxc;
    wire         hreadyout, hresp, observe_pin;
    wire  [31:0] hrdata;
    wire  [4:0]  ana_ch, node;
    wire  [12:0] node_en;
    int          fail_count, checks_done;

    tsom_observe_mux dut (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .tx_active,
        .tx_nrz(src[7]), .tx_envelope(src[8]), .tx_enc_clk(src[4]),
        .rx_manch_sub(src[6]), .rx_manch(src[5]), .rx_clk(src[3]),
        .rx_bit_start(rxc[4]), .rx_bit_done(rxc[3]), .rx_bit_data(rxc[2]),
        .rx_coll_det(rxc[1]), .rx_frame_end(rxc[0]), .host_rd_sync(src[2]),
        .host_wr_sync(src[1]), .core_clk_level(src[0]), .observe_pin,
        .analog_probe_choice(ana_ch), .analog_node_en(node_en)
    );

    tsom_probe u_probe (.hclk, .analog_node_en(node_en), .node_q(node));

    always #12.5 hclk = ~hclk;

    task end_sim;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // waits for hready high at a falling edge, takes hrdata there, then moves on to the next rising edge
    task wt;
        int n;
        n = 0;
        @(negedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                fail_count++;
                end_sim;
            end
            @(negedge hclk);
        end
        rd_q = hrdata;
        @(posedge hclk);
    endtask

    task bus(input bit w, input [7:0] a, input [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        wt;
        htrans <= 2'h0;
        hwdata <= d;
        wt;
    endtask

    task pchk(input bit e);
        repeat (2) @(posedge hclk);
        @(negedge hclk);
        chk("observe pin", observe_pin, e);
    endtask

    task obs(input [8:0] v, input bit e);
        @(posedge hclk) src <= v;
        pchk(e);
    endtask

    task pulse(input [4:0] v);
        @(posedge hclk) rxc <= v;
        @(posedge hclk) rxc <= 5'h00;
    endtask

    task rx_bit(input bit d, input bit c);
        pulse(5'h10);
        @(posedge hclk) rxc <= {3'h0, c, 1'b0};
        pulse({2'h1, d, 2'h0});
    endtask

    task s_zero;
        int i;
        for (i = 0; i < 12; i += 4) begin
            bus(0, i[7:0], 0);
            chk("reset value", rd_q, 0);
        end
    endtask

    task s_bus;
        bus(1, 8'h00, 32'hFFFF_FFF9);
        bus(1, 8'h10, 32'h5);
        bus(0, 8'h00, 0);
        chk("observe reg", rd_q, 32'h9);
        bus(0, 8'h10, 0);
        chk("unmapped", rd_q, 0);
        chk("response", hresp, 0);
        pchk(1);
        bus(0, 8'h0C, 0);
        chk("status", rd_q, 32'h0000_0C2A);
    endtask

    task s_sel;
        int s, p;
        for (s = 0; s < 8; s++) begin
            bus(1, 8'h00, s);
            for (p = 0; p < 2; p++)
                obs(p ? 9'h1 << (10 - s) : ~(9'h1 << (10 - s)),
                    s == 1 || (s > 1 && s < 6 && p == 1));
        end
    endtask

    task s_route;
        logic [7:0] cd [5];
        int i, p;
        cd = '{8'hC4, 8'hC4, 8'hB5, 8'hA5, 8'h96};
        bus(1, 8'h00, 32'h9);
        for (i = 0; i < 5; i++) begin
            bus(1, 8'h08, cd[i]);
            tx_active <= (i == 0);
            for (p = 0; p < 2; p++)
                obs(p ? 9'h10 >> i : ~(9'h10 >> i), p);
        end
        bus(1, 8'h08, 0);
        obs(9'h0, 1);
    endtask

    task s_rx;
        logic [7:0] cd [3];
        logic [2:0] v;
        int i, j;
        cd = '{8'hF4, 8'hD4, 8'hE4};
        bus(1, 8'h00, 32'h8);
        for (i = 0; i < 4; i++) begin
            v = {1'b1, i[0], i[1]};
            rx_bit(v[0], v[1]);
            bus(0, 8'h0C, 0);
            chk("rx status", rd_q[9:7], {v[1], 1'b1, v[0]});
            for (j = 0; j < 3; j++) begin
                bus(1, 8'h08, cd[j]);
                pchk(v[j]);
            end
        end
        pulse(5'h01);
        pchk(0);
        rx_bit(1, 0);
        pulse(5'h10);
        pchk(0);
        bus(1, 8'h08, 0);
    endtask

    task s_ana;
        int c;
        for (c = 0; c < 32; c++) begin
            bus(1, 8'h04, 32'hFFFF_FFE0 | c);
            repeat (3) @(posedge hclk);
            @(negedge hclk);
            chk("analog choice", ana_ch, c);
            chk("probed node", node, c < 13 ? c : 31);
        end
    endtask

    task s_rst;
        bus(1, 8'h00, 32'h1);
        pchk(1);
        @(posedge hclk) hresetn <= 1'b0;
        @(negedge hclk);
        chk("pin in reset", observe_pin, 0);
        @(posedge hclk) hresetn <= 1'b1;
        s_zero;
    endtask

    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsize = 3'h2;
        {hsel, hwrite, tx_active, haddr, htrans, hwdata, src, rxc} = '0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        s_zero;
        s_bus;
        s_sel;
        s_route;
        s_rx;
        s_ana;
        s_rst;
        end_sim;
    end
endmodule // tb
